/* imu_spi_pkg.sv */
/*
 * Constants and types for the register-mapped SPI slave port of an
 * inertial sensor unit and its built-in-test health word.
 * Assumes the sensor core delivers samples, faults and timestamps on clk.
 */
package imu_spi_pkg;

    localparam int         WORD_BITS      = 16;
    localparam int         SYNC_DEPTH     = 2;

    // Read addresses (even, two bytes returned)
    localparam logic [7:0] ADDR_GYRO_X    = 8'h04;
    localparam logic [7:0] ADDR_GYRO_Y    = 8'h06;
    localparam logic [7:0] ADDR_GYRO_Z    = 8'h08;
    localparam logic [7:0] ADDR_ACCEL_X   = 8'h0a;
    localparam logic [7:0] ADDR_ACCEL_Y   = 8'h0c;
    localparam logic [7:0] ADDR_ACCEL_Z   = 8'h0e;
    localparam logic [7:0] ADDR_GYRO_TEMP = 8'h16;
    localparam logic [7:0] ADDR_PCB_TEMP  = 8'h18;
    localparam logic [7:0] ADDR_TEST_DRDY = 8'h34;
    localparam logic [7:0] ADDR_RATE_SEL  = 8'h36;
    localparam logic [7:0] ADDR_RANGE_FLT = 8'h38;
    localparam logic [7:0] ADDR_ALERT_EN  = 8'h3a;
    localparam logic [7:0] ADDR_DIAG      = 8'h3c;
    localparam logic [7:0] ADDR_BUILD     = 8'h52;
    localparam logic [7:0] ADDR_UNIT_INFO = 8'h54;

    // Burst commands
    localparam logic [7:0] ADDR_BURST_STD = 8'h3e;
    localparam logic [7:0] ADDR_BURST_EXT = 8'h3f;
    localparam logic [7:0] ADDR_BURST_S0  = 8'h41;
    localparam logic [7:0] ADDR_BURST_S1  = 8'h42;

    // Write addresses (one byte each)
    localparam logic [6:0] WADDR_SELFTEST = 7'h35;
    localparam logic [6:0] WADDR_DRDY     = 7'h34;
    localparam logic [6:0] WADDR_RATE_SEL = 7'h37;
    localparam logic [6:0] WADDR_RANGE    = 7'h39;
    localparam logic [6:0] WADDR_FILTER   = 7'h38;
    localparam logic [6:0] WADDR_ALERT_EN = 7'h3b;
    localparam int         WRITE_FLAG_BIT = 15;

    // Values after reset
    localparam logic [7:0] RST_SELFTEST   = 8'h00;
    localparam logic [7:0] RST_DRDY       = 8'h04;
    localparam logic [7:0] RST_RATE_SEL   = 8'h01;
    localparam logic [7:0] RST_RANGE      = 8'h02;
    localparam logic [7:0] RST_FILTER     = 8'h06;

    // Health word bit positions
    localparam int         HB_FATAL       = 0;
    localparam int         HB_HW_FAULT    = 1;
    localparam int         HB_LINK_FAULT  = 2;
    localparam int         HB_FW_FAULT    = 3;
    localparam int         HB_SUMMARY     = 8;
    localparam int         HB_HW_ALERT    = 9;
    localparam int         HB_LINK_ALERT  = 10;
    localparam int         HB_FW_ALERT    = 11;
    localparam int         HB_OVERRANGE   = 12;

    // Burst packet lengths in words
    localparam logic [3:0] LEN_STD        = 4'h9;
    localparam logic [3:0] LEN_EXT        = 4'hb;
    localparam logic [3:0] LEN_S0         = 4'h9;
    localparam logic [3:0] LEN_S1         = 4'h7;
    localparam int         PKT_WORDS      = 11;

    typedef struct packed {
        logic [15:0] gyro_x;
        logic [15:0] gyro_y;
        logic [15:0] gyro_z;
        logic [15:0] accel_x;
        logic [15:0] accel_y;
        logic [15:0] accel_z;
        logic [15:0] gyro_temp;
        logic [15:0] pcb_temp;
    } sensor_set_t;

    typedef struct packed {
        logic fatal;
        logic hw;
        logic link;
        logic fw;
    } fault_set_t;

    typedef struct packed {
        logic sensor;
        logic fw;
        logic link;
        logic hw;
    } alert_en_t;

    localparam alert_en_t  RST_ALERT_EN   = 4'h8;

    typedef struct packed {
        logic [15:0] sample_to_sync_time;
        logic [15:0] sync_to_ready_time;
    } stamps_t;

endpackage : imu_spi_pkg

/* imu_spi_slave.sv */
/*
 * SPI slave (mode 3, 16-bit words, MSB first) with polled register reads,
 * burst packet reads, byte writes to configuration, and the health word.
 * Assumes sclk, cs_n and mosi come from pins asynchronous to clk, sclk is
 * much slower than clk, and all other inputs are synchronous to clk.
 */
// Functional notes
// - Two-byte health word, error flags low byte, alerts high byte, leads every packet.
// - Bit 0 is the fatal failure flag, 1 while the core reports a fatal fault.
// - Bits 1,2,3 flag hardware, communication and software faults.
// - Bit 8 is set when any enabled alert source is set.
// - Bit 12 reports sensor over-range when the sensor alert is enabled.
// - Alerts enabled per type; after reset only the sensor alert is enabled.
// - Over-range comes from rate sensors only, never from accelerometers.
// - Device is a slave only; it answers transfers the master starts.
// - All link transfers are 16-bit words, most significant bit first.
// - Clock idles high; data sampled on rising edge, driven on falling edge.
// - Paired bytes read together at first address, each written at its own.
// - Read command 0x3E starts standard burst, 0x3F extended burst.
// - Read commands 0x41 and 0x42 start scaled type 0 and 1 bursts.
// - Only the extended burst carries the two microsecond timestamps.
// - Burst packets carry separately scaled sensor data, not register scaling.
// - Self-test and data-ready read at 0x34; self-test write starts test; data-ready 0x04.
// - Output data rate read at 0x36, 0x01 after reset.
// - Gyro range 0x02 and filter 0x06 read at 0x38, written crosswise.
// - Read-only diagnostic status at 0x3C.
// - Build code at 0x52 and unit information code at 0x54, read only.
// - Read command is address then zero byte; answer in next 16 clocks.
// - Reads return two bytes, writes carry one byte.
module imu_spi_slave #(
    parameter logic [15:0] BUILD_CODE     = 16'h00c3,  // Arbitrary value
    parameter logic [15:0] UNIT_INFO_CODE = 16'h0001   // Arbitrary value
) (
    input  wire logic                      clk,
    input  wire logic                      rstn,
    input  wire logic                      sclk,
    input  wire logic                      chip_select_n,
    input  wire logic                      mosi,
    output logic                           miso,
    output logic                           miso_oe_n,
    input  wire imu_spi_pkg::sensor_set_t  raw_data,
    input  wire imu_spi_pkg::sensor_set_t  scaled_data,
    input  wire imu_spi_pkg::stamps_t      stamps,
    input  wire imu_spi_pkg::fault_set_t   faults,
    input  wire logic                      gyro_overrange,
    input  wire logic [15:0]               diag_status,
    output logic [15:0]                    health_word,
    output logic                           selftest_start,
    output logic [7:0]                     selftest_trigger,
    output logic [7:0]                     drdy_config,
    output logic [7:0]                     sample_rate_select,
    output logic [7:0]                     gyro_range_select,
    output logic [7:0]                     filter_cutoff_select
);

    logic [2:0]                  sync1_reg;
    logic [2:0]                  sync2_reg;
    logic                        sclk_prev_reg;
    logic                        sclk_s;
    logic                        cs_n_s;
    logic                        mosi_s;
    logic                        rise;
    logic                        fall;
    logic                        sel;
    logic [3:0]                  bit_cnt_reg;
    logic [15:0]                 rx_reg;
    logic [15:0]                 rx_word;
    logic                        word_done;
    logic [15:0]                 tx_reg;
    logic [15:0]                 reply_next;
    logic [15:0]                 read_data;
    logic [3:0]                  burst_len_reg;
    logic [3:0]                  burst_idx_reg;
    logic [15:0]                 pkt [0:imu_spi_pkg::PKT_WORDS-1];
    imu_spi_pkg::alert_en_t      alert_en_reg;
    logic                        wr_cmd;
    logic [6:0]                  wr_addr;
    logic [7:0]                  wr_data;
    logic [7:0]                  rd_addr;
    logic [3:0]                  start_len;

    // Two-stage synchronisers for pin inputs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            // Idle pin levels, so no false sclk edge follows reset
            sync1_reg     <= 3'h7;
            sync2_reg     <= 3'h7;
            sclk_prev_reg <= 1'b1;
        end else begin
            sync1_reg     <= {sclk, chip_select_n, mosi};
            sync2_reg     <= sync1_reg;
            sclk_prev_reg <= sync2_reg[2];
        end
    end

    assign sclk_s = sync2_reg[2];
    assign cs_n_s = sync2_reg[1];
    assign mosi_s = sync2_reg[0];
    assign sel    = !cs_n_s;
    assign rise   = sel && sclk_s && !sclk_prev_reg;
    assign fall   = sel && !sclk_s && sclk_prev_reg;

    // Bit counter and receive shifter
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bit_cnt_reg <= 4'h0;
            rx_reg      <= 16'h0000;
        end else if (!sel) begin
            bit_cnt_reg <= 4'h0;
        end else if (rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            rx_reg      <= rx_word;
        end
    end

    assign rx_word   = {rx_reg[14:0], mosi_s};
    assign word_done = rise && (bit_cnt_reg == 4'hf);
    assign wr_cmd    = rx_word[imu_spi_pkg::WRITE_FLAG_BIT];
    assign wr_addr   = rx_word[14:8];
    assign wr_data   = rx_word[7:0];
    assign rd_addr   = rx_word[15:8];

    // Packet word list; shorter packets use its head
    always_comb begin
        pkt[0]  = health_word;
        pkt[1]  = scaled_data.gyro_x;
        pkt[2]  = scaled_data.gyro_y;
        pkt[3]  = scaled_data.gyro_z;
        pkt[4]  = scaled_data.accel_x;
        pkt[5]  = scaled_data.accel_y;
        pkt[6]  = scaled_data.accel_z;
        pkt[7]  = scaled_data.gyro_temp;
        pkt[8]  = scaled_data.pcb_temp;
        pkt[9]  = stamps.sample_to_sync_time;
        pkt[10] = stamps.sync_to_ready_time;
    end

    // Polled register read map
    always_comb begin
        unique case ({rd_addr[7:1], 1'b0})
            imu_spi_pkg::ADDR_GYRO_X:    read_data = raw_data.gyro_x;
            imu_spi_pkg::ADDR_GYRO_Y:    read_data = raw_data.gyro_y;
            imu_spi_pkg::ADDR_GYRO_Z:    read_data = raw_data.gyro_z;
            imu_spi_pkg::ADDR_ACCEL_X:   read_data = raw_data.accel_x;
            imu_spi_pkg::ADDR_ACCEL_Y:   read_data = raw_data.accel_y;
            imu_spi_pkg::ADDR_ACCEL_Z:   read_data = raw_data.accel_z;
            imu_spi_pkg::ADDR_GYRO_TEMP: read_data = raw_data.gyro_temp;
            imu_spi_pkg::ADDR_PCB_TEMP:  read_data = raw_data.pcb_temp;
            imu_spi_pkg::ADDR_TEST_DRDY: read_data = {selftest_trigger, drdy_config};
            imu_spi_pkg::ADDR_RATE_SEL:  read_data = {sample_rate_select, 8'h00};
            imu_spi_pkg::ADDR_RANGE_FLT: read_data = {gyro_range_select, filter_cutoff_select};
            imu_spi_pkg::ADDR_ALERT_EN:  read_data = {12'h000, alert_en_reg};
            imu_spi_pkg::ADDR_DIAG:      read_data = diag_status;
            imu_spi_pkg::ADDR_BUILD:     read_data = BUILD_CODE;
            imu_spi_pkg::ADDR_UNIT_INFO: read_data = UNIT_INFO_CODE;
            default:                     read_data = 16'h0000;
        endcase
    end

    // Burst command decode
    always_comb begin
        unique case (rd_addr)
            imu_spi_pkg::ADDR_BURST_STD: start_len = imu_spi_pkg::LEN_STD;
            imu_spi_pkg::ADDR_BURST_EXT: start_len = imu_spi_pkg::LEN_EXT;
            imu_spi_pkg::ADDR_BURST_S0:  start_len = imu_spi_pkg::LEN_S0;
            imu_spi_pkg::ADDR_BURST_S1:  start_len = imu_spi_pkg::LEN_S1;
            default:                     start_len = 4'h0;
        endcase
    end

    // Word to send during the next 16 clocks
    always_comb begin
        if (wr_cmd) begin
            reply_next = 16'h0000;
        end else if (start_len != 4'h0 && rx_word[7:0] == 8'h00) begin
            reply_next = pkt[0];
        end else if (rx_word == 16'h0000 && burst_idx_reg < burst_len_reg) begin
            reply_next = pkt[burst_idx_reg];
        end else if (rx_word[7:0] == 8'h00) begin
            reply_next = read_data;
        end else begin
            reply_next = 16'h0000;
        end
    end

    // Burst progress; ends on any other command or deselect
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            burst_len_reg <= 4'h0;
            burst_idx_reg <= 4'h0;
        end else if (!sel) begin
            burst_len_reg <= 4'h0;
            burst_idx_reg <= 4'h0;
        end else if (word_done) begin
            if (!wr_cmd && start_len != 4'h0 && rx_word[7:0] == 8'h00) begin
                burst_len_reg <= start_len;
                burst_idx_reg <= 4'h1;
            end else if (rx_word == 16'h0000 && burst_idx_reg < burst_len_reg) begin
                burst_idx_reg <= burst_idx_reg + 4'h1;
            end else begin
                burst_len_reg <= 4'h0;
                burst_idx_reg <= 4'h0;
            end
        end
    end

    // Transmit word and pin drive
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_reg    <= 16'h0000;
            miso      <= 1'b0;
            miso_oe_n <= 1'b1;
        end else begin
            miso_oe_n <= cs_n_s;
            if (!sel) begin
                tx_reg <= 16'h0000;
            end else if (word_done) begin
                tx_reg <= reply_next;
            end
            if (fall) begin
                miso <= tx_reg[4'hf - bit_cnt_reg];
            end
        end
    end

    // Configuration byte writes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            selftest_trigger     <= imu_spi_pkg::RST_SELFTEST;
            drdy_config          <= imu_spi_pkg::RST_DRDY;
            sample_rate_select   <= imu_spi_pkg::RST_RATE_SEL;
            gyro_range_select    <= imu_spi_pkg::RST_RANGE;
            filter_cutoff_select <= imu_spi_pkg::RST_FILTER;
            alert_en_reg         <= imu_spi_pkg::RST_ALERT_EN;
            selftest_start       <= 1'b0;
        end else begin
            selftest_start <= word_done && wr_cmd && wr_addr == imu_spi_pkg::WADDR_SELFTEST;
            if (word_done && wr_cmd) begin
                unique case (wr_addr)
                    imu_spi_pkg::WADDR_SELFTEST: selftest_trigger     <= wr_data;
                    imu_spi_pkg::WADDR_DRDY:     drdy_config          <= wr_data;
                    imu_spi_pkg::WADDR_RATE_SEL: sample_rate_select   <= wr_data;
                    imu_spi_pkg::WADDR_RANGE:    gyro_range_select    <= wr_data;
                    imu_spi_pkg::WADDR_FILTER:   filter_cutoff_select <= wr_data;
                    imu_spi_pkg::WADDR_ALERT_EN: alert_en_reg         <= wr_data[3:0];
                    default:                     selftest_trigger     <= selftest_trigger;
                endcase
            end
        end
    end

    // Health word
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            health_word <= 16'h0000;
        end else begin
            health_word                            <= 16'h0000;
            health_word[imu_spi_pkg::HB_FATAL]     <= faults.fatal;
            health_word[imu_spi_pkg::HB_HW_FAULT]  <= faults.hw;
            health_word[imu_spi_pkg::HB_LINK_FAULT] <= faults.link;
            health_word[imu_spi_pkg::HB_FW_FAULT]  <= faults.fw;
            health_word[imu_spi_pkg::HB_HW_ALERT]  <= faults.hw && alert_en_reg.hw;
            health_word[imu_spi_pkg::HB_LINK_ALERT] <= faults.link && alert_en_reg.link;
            health_word[imu_spi_pkg::HB_FW_ALERT]  <= faults.fw && alert_en_reg.fw;
            health_word[imu_spi_pkg::HB_OVERRANGE] <= gyro_overrange && alert_en_reg.sensor;
            health_word[imu_spi_pkg::HB_SUMMARY]   <= (faults.hw && alert_en_reg.hw)
                                                    || (faults.link && alert_en_reg.link)
                                                    || (faults.fw && alert_en_reg.fw)
                                                    || (gyro_overrange && alert_en_reg.sensor);
        end
    end

    property p_fatal;
        @(posedge clk) disable iff (!rstn)
        faults.fatal |=> health_word[0];
    endproperty
    a_fatal: assert property (p_fatal) else $error("fatal flag missing");

    property p_summary;
        @(posedge clk) disable iff (!rstn)
        health_word[8] == (|health_word[12:9]);
    endproperty
    a_summary: assert property (p_summary) else $error("summary alert mismatch");

    property p_overrange;
        @(posedge clk) disable iff (!rstn)
        health_word[12] |-> $past(gyro_overrange);
    endproperty
    a_overrange: assert property (p_overrange) else $error("over-range without rate cause");

    property p_alert_gate;
        @(posedge clk) disable iff (!rstn)
        !alert_en_reg.hw |=> !health_word[9];
    endproperty
    a_alert_gate: assert property (p_alert_gate) else $error("disabled alert shown");

    property p_miso_edge;
        @(posedge clk) disable iff (!rstn)
        $changed(miso) |-> $past(fall);
    endproperty
    a_miso_edge: assert property (p_miso_edge) else $error("miso moved off falling edge");

    property p_release;
        @(posedge clk) disable iff (!rstn)
        !sel |=> miso_oe_n;
    endproperty
    a_release: assert property (p_release) else $error("miso driven while deselected");

    property p_word;
        @(posedge clk) disable iff (!rstn)
        word_done |=> bit_cnt_reg == 4'h0 ##0 tx_reg == $past(reply_next);
    endproperty
    a_word: assert property (p_word) else $error("word boundary wrong");

    property p_burst;
        @(posedge clk) disable iff (!rstn)
        word_done && rx_word == 16'h3e00 |=> tx_reg == $past(health_word) ##0 burst_len_reg == 4'h9;
    endproperty
    a_burst: assert property (p_burst) else $error("standard burst not started");

    property p_drdy_write;
        @(posedge clk) disable iff (!rstn)
        word_done && rx_word[15:8] == 8'hb4 |=> drdy_config == $past(rx_word[7:0]);
    endproperty
    a_drdy_write: assert property (p_drdy_write) else $error("data-ready write lost");

    property p_selftest;
        @(posedge clk) disable iff (!rstn)
        word_done && rx_word[15:8] == 8'hb5 |=> selftest_start ##1 !selftest_start;
    endproperty
    a_selftest: assert property (p_selftest) else $error("self-test pulse wrong");

    property p_reserved;
        @(posedge clk) disable iff (!rstn)
        word_done && rx_word == 16'h1000 |=> tx_reg == 16'h0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved read not zero");

endmodule : imu_spi_slave

/* spi_master_model.sv */
/*
 * Behavioural SPI master: mode 3, 16-bit words, MSB first, 32 ns link clock.
 * Assumes the bench calls its tasks one at a time and sees miso as resolved by enable.
 */
module spi_master_model (
    output logic      sclk,
    output logic      chip_select_n,
    output logic      mosi,
    input  wire logic miso
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF = 16;
    int            idle_gap = 0;

    initial begin
        sclk          = 1'b1;
        chip_select_n = 1'b1;
        mosi          = 1'b1;
    end

    // Edges land on odd nanoseconds, never on a clk edge
    task automatic open_frame();
        if ($time % 2 == 0) #1;
        chip_select_n = 1'b0;
        #(4 * HALF);
    endtask : open_frame

    task automatic close_frame();
        #(HALF);
        chip_select_n = 1'b1;
        mosi          = ~mosi;
        #(8 * HALF);
    endtask : close_frame

    task automatic word(input logic [15:0] tx, output logic [15:0] rx);
        #(idle_gap);
        for (int i = 15; i >= 0; i--) begin
            sclk = 1'b0;
            mosi = tx[i];
            #(HALF);
            sclk = 1'b1;
            // Sampled late in the high phase to ride out the slave's sync lag
            #(HALF - 2);
            rx[i] = miso;
            #2;
        end
    endtask : word
endmodule : spi_master_model

/* inertial_spi_slave_regs_bench.sv */
/*
 * Self-checking bench for the SPI register slave and its health word.
 * Assumes the partner model in spi_master_model.sv and the package imu_spi_pkg.
 */
module inertial_spi_slave_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] BUILD = 16'h0a5e;  // Arbitrary value
    localparam logic [15:0] UNIT  = 16'h0c07;  // Arbitrary value
    localparam int          LIMIT = 40000;
    logic clk, rstn, sclk, chip_select_n, mosi, miso, miso_oe_n, gyro_overrange, selftest_start;
    imu_spi_pkg::sensor_set_t raw_data, scaled_data;
    imu_spi_pkg::stamps_t     stamps;
    imu_spi_pkg::fault_set_t  faults;
    logic [15:0] diag_status, health_word;
    logic [7:0]  selftest_trigger, drdy_config, sample_rate_select, gyro_range_select, filter_cutoff_select;
    int          num_errors = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          pulses = 0;
    wire         miso_line = miso_oe_n ? ~miso : miso;

    imu_spi_slave #(.BUILD_CODE(BUILD), .UNIT_INFO_CODE(UNIT)) DUT (
        .clk(clk), .rstn(rstn), .sclk(sclk), .chip_select_n(chip_select_n), .mosi(mosi),
        .miso(miso), .miso_oe_n(miso_oe_n), .raw_data(raw_data), .scaled_data(scaled_data),
        .stamps(stamps), .faults(faults), .gyro_overrange(gyro_overrange), .diag_status(diag_status),
        .health_word(health_word), .selftest_start(selftest_start), .selftest_trigger(selftest_trigger),
        .drdy_config(drdy_config), .sample_rate_select(sample_rate_select),
        .gyro_range_select(gyro_range_select), .filter_cutoff_select(filter_cutoff_select)
    );
    spi_master_model m (.sclk(sclk), .chip_select_n(chip_select_n), .mosi(mosi), .miso(miso_line));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(negedge clk) begin
        cycles++;
        if (selftest_start === 1'b1) pulses++;
        if (cycles == LIMIT) begin
            num_errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic step(input logic [15:0] tx, input logic [15:0] exp);
        logic [15:0] r;
        m.word(tx, r);
        chk(r, exp);
    endtask : step

    task automatic wr(input logic [15:0] w);
        m.open_frame();
        step(w, 16'h0000);
        m.close_frame();
    endtask : wr

    task automatic t_reset();
        chk({selftest_trigger, drdy_config}, 16'h0004);
        chk({sample_rate_select, 8'h00}, 16'h0100);
        chk({gyro_range_select, filter_cutoff_select}, 16'h0206);
        chk({15'h0000, miso_oe_n}, 16'h0001);
        m.open_frame();
        step(16'h3400, 16'h0000);
        step(16'h3600, 16'h0004);
        step(16'h3800, 16'h0100);
        step(16'h0000, 16'h0206);
        m.close_frame();
    endtask : t_reset

    task automatic t_polled();
        m.open_frame();
        step(16'h0400, 16'h0000);
        step(16'h0e00, raw_data.gyro_x);
        step(16'h5200, raw_data.accel_z);
        step(16'h5400, BUILD);
        step(16'h3c00, UNIT);
        step(16'h1000, diag_status);
        step(16'h0000, 16'h0000);
        m.close_frame();
    endtask : t_polled

    task automatic t_write();
        m.idle_gap = 200;
        wr(16'hb5a7);
        chk(16'(pulses), 16'h0001);
        chk({8'h00, selftest_trigger}, 16'h00a7);
        m.open_frame();
        step(16'hb833, 16'h0000);
        step(16'hb944, 16'h0000);
        step(16'hb712, 16'h0000);
        step(16'hb455, 16'h0000);
        step(16'h90ee, 16'h0000);
        step(16'h3400, 16'h0000);
        step(16'h3600, 16'ha755);
        step(16'h3800, 16'h1200);
        step(16'h0000, 16'h4433);
        m.close_frame();
        m.idle_gap = 0;
        chk({gyro_range_select, filter_cutoff_select}, 16'h4433);
        chk({sample_rate_select, drdy_config}, 16'h1255);
    endtask : t_write

    task automatic hcase(input logic [3:0] f, input logic ov, input logic [15:0] exp);
        @(negedge clk);
        faults         = f;
        gyro_overrange = ov;
        repeat (3) @(negedge clk);
        chk(health_word, exp);
    endtask : hcase

    task automatic t_health();
        hcase(4'ha, 1'b1, 16'h1105);
        hcase(4'h5, 1'b0, 16'h000a);
        wr(16'hbb0f);
        hcase(4'ha, 1'b1, 16'h1505);
        hcase(4'h4, 1'b0, 16'h0302);
        wr(16'hbb00);
        hcase(4'h4, 1'b1, 16'h0002);
        wr(16'hbb08);
        hcase(4'h0, 1'b1, 16'h1100);
    endtask : t_health

    task automatic burst(input logic [7:0] cmd, input int n);
        logic [15:0] pkt [0:10];
        pkt[0]  = 16'h1100;
        pkt[9]  = stamps.sample_to_sync_time;
        pkt[10] = stamps.sync_to_ready_time;
        for (int i = 0; i < 8; i++) pkt[i + 1] = scaled_data[127 - 16 * i -: 16];
        m.open_frame();
        step({cmd, 8'h00}, 16'h0000);
        for (int i = 0; i < n; i++) step(16'h0000, pkt[i]);
        step(16'h0000, 16'h0000);
        m.close_frame();
    endtask : burst

    initial begin
        rstn           = 1'b0;
        raw_data       = 128'h0104_0106_0108_010a_010c_010e_0116_0118;
        scaled_data    = 128'h2001_2002_2003_2004_2005_2006_2007_2008;
        stamps         = 32'h3a3a_5c5c;
        faults         = 4'h0;
        gyro_overrange = 1'b0;
        diag_status    = 16'h5a3c;
        repeat (10) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        chk(health_word, 16'h0000);
        t_reset();
        t_polled();
        t_write();
        t_health();
        burst(imu_spi_pkg::ADDR_BURST_STD, 9);
        burst(imu_spi_pkg::ADDR_BURST_EXT, 11);
        burst(imu_spi_pkg::ADDR_BURST_S0, 9);
        burst(imu_spi_pkg::ADDR_BURST_S1, 7);
        end_sim();
    end
endmodule : inertial_spi_slave_regs_bench
